/* File: mmc_regs.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// (RL1) Mode 0: positioning with full profile
// (RL2) Mode 1: ramp to plus limit, max acceleration
// (RL3) Mode 2: ramp to minus limit, max acceleration
// (RL4) Mode 3: keep velocity until stop event
// (RL5) Five-bit index selects window's table word
// (RL6) Index 0-7 words, 8 start, 9 segment
// (RL7) Compare value is absolute, not offset
// (RL8) Pulse high while position equals compare
// (RL9) Pulse low once position mismatches
// (RL10) Diagnostic pin shows pulse only when enabled
// (RL11) Repeat above one: compare is base
// (RL12) Pulse at every multiple of repeat distance
// (RL13) Window access hits only indexed word
module mmc_regs (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] current_position,
  input wire logic [23:0] repeat_distance,
  input wire logic pulse_enable,
  input wire logic [31:0] velocity_limit,
  input wire logic [31:0] acceleration_limit,
  input wire logic [31:0] present_velocity,
  input wire logic stop_event,
  output logic [1:0] motion_profile_select,
  output logic ramp_full_profile,
  output logic [31:0] ramp_target_velocity,
  output logic [31:0] ramp_acceleration,
  output logic position_pulse,
  output logic diagnostic_output_two,
  output logic [mmc_pkg::LUT_WORDS-1:0][31:0] table_words
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rd_pend;
    logic [7:0] ar_addr;
    logic [4:0] ar_lidx;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [4:0] table_index;
    logic [31:0] compare;
    logic full_profile;
    logic [31:0] target_vel;
    logic [31:0] accel;
    logic pulse;
    logic diag;
  } mmc_state_t;

  mmc_state_t st_r;
  mmc_state_t st_nxt;

  logic mem_wr_en;
  logic [3:0] mem_wr_idx;
  logic mem_rd_en;
  logic [3:0] mem_rd_idx;
  logic [31:0] mem_rd_data;
  logic [mmc_pkg::LUT_WORDS-1:0][31:0] mem_words;

  logic [5:0] widx;
  logic [5:0] ridx;
  logic [31:0] pos_diff;
  logic [31:0] pos_dist;
  logic [31:0] rep_ext;
  logic match_now;
  logic [31:0] mode_merged;
  logic [31:0] lidx_merged;
  logic [31:0] lut_pick;
  logic wr_commit;

  assign widx = st_r.aw_addr[7:2];
  assign ridx = st_r.ar_addr[7:2];

  // Absolute compare; with a repeat the distance from the base must be a whole
  // multiple in either direction. The modulo is a wide divider, paid for in area
  assign pos_diff = current_position - st_r.compare; // RL7 RL11
  assign pos_dist = pos_diff[31] ? (32'h00000000 - pos_diff) : pos_diff;
  assign rep_ext = {8'h00, repeat_distance};
  assign match_now = (repeat_distance > mmc_pkg::REP_ONE) ?
                     ((pos_dist % rep_ext) == 32'h00000000) : // RL12
                     (current_position == st_r.compare); // RL8

  // Byte-lane merges kept as nets; a select on a call result is not portable
  assign mode_merged = mmc_pkg::merge({30'h0, st_r.mode}, st_r.w_data, st_r.w_strb);
  assign lidx_merged = mmc_pkg::merge({27'h0, st_r.table_index}, st_r.w_data, st_r.w_strb);

  mmc_lut_mem u_lut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(mem_wr_en),
    .wr_idx(mem_wr_idx),
    .wr_data(st_r.w_data),
    .wr_strb(st_r.w_strb),
    .rd_en(mem_rd_en),
    .rd_idx(mem_rd_idx),
    .rd_data(mem_rd_data),
    .words(mem_words)
  );

  // Bus slave, register writes, ramp selection and compare
  always_comb begin
    st_nxt = st_r;
    mem_wr_en = 1'b0;
    mem_wr_idx = st_r.table_index[3:0];
    mem_rd_en = 1'b0;
    mem_rd_idx = st_r.table_index[3:0];
    // Address and data taken in either order, each held until the write
    if (st_r.awready && s_axi_awvalid) begin
      st_nxt.awready = 1'b0;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (st_r.wready && s_axi_wvalid) begin
      st_nxt.wready = 1'b0;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (!st_r.awready && !st_r.wready && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mmc_pkg::RESP_OKAY;
      if (st_r.aw_addr[1:0] != 2'h0) begin
        st_nxt.bresp = mmc_pkg::RESP_SLVERR;
      end else begin
        case (widx)
          mmc_pkg::IDX_RAMP: begin
            st_nxt.mode = mode_merged[1:0];
          end
          mmc_pkg::IDX_LIDX: begin
            st_nxt.table_index = lidx_merged[4:0]; // RL5
          end
          mmc_pkg::IDX_LWIN: begin
            // Index outside the table: write is dropped quietly
            mem_wr_en = (st_r.table_index < mmc_pkg::LUT_WORDS); // RL6 RL13
          end
          mmc_pkg::IDX_CMP: begin
            st_nxt.compare = mmc_pkg::merge(st_r.compare, st_r.w_data, st_r.w_strb); // RL7
          end
          mmc_pkg::IDX_STAT: begin
            st_nxt.bresp = mmc_pkg::RESP_OKAY;
          end
          default: begin
            st_nxt.bresp = mmc_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end
    // Reads: index frozen at acceptance, data two cycles later for every register
    if (st_r.arready && s_axi_arvalid) begin
      st_nxt.arready = 1'b0;
      st_nxt.ar_addr = s_axi_araddr;
      st_nxt.ar_lidx = st_r.table_index; // RL13
      st_nxt.rd_pend = 1'b1;
      mem_rd_en = (st_r.table_index < mmc_pkg::LUT_WORDS); // RL5
    end
    if (st_r.rd_pend) begin
      st_nxt.rd_pend = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = mmc_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      if (st_r.ar_addr[1:0] != 2'h0) begin
        st_nxt.rresp = mmc_pkg::RESP_SLVERR;
      end else begin
        case (ridx)
          mmc_pkg::IDX_RAMP: st_nxt.rdata = {30'h0, st_r.mode};
          mmc_pkg::IDX_LIDX: st_nxt.rdata = {27'h0, st_r.table_index};
          mmc_pkg::IDX_LWIN: begin
            if (st_r.ar_lidx < mmc_pkg::LUT_WORDS) begin
              st_nxt.rdata = mem_rd_data; // RL6
            end
          end
          mmc_pkg::IDX_CMP: st_nxt.rdata = st_r.compare;
          mmc_pkg::IDX_STAT: begin
            st_nxt.rdata[mmc_pkg::STAT_PULSE_BIT] = st_r.pulse;
            st_nxt.rdata[mmc_pkg::STAT_MODE_LSB +: 2] = st_r.mode;
          end
          default: st_nxt.rresp = mmc_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    // Ramp targets follow the selected profile
    st_nxt.full_profile = 1'b0;
    st_nxt.accel = acceleration_limit;
    case (st_r.mode)
      mmc_pkg::MODE_POSITION: begin
        st_nxt.full_profile = 1'b1; // RL1
        st_nxt.target_vel = velocity_limit;
      end
      mmc_pkg::MODE_VEL_POS: st_nxt.target_vel = velocity_limit; // RL2
      mmc_pkg::MODE_VEL_NEG: st_nxt.target_vel = 32'h00000000 - velocity_limit; // RL3
      mmc_pkg::MODE_HOLD: begin
        // Velocity frozen; only a stop event brings it down
        st_nxt.target_vel = stop_event ? 32'h00000000 : present_velocity; // RL4
      end
      default: st_nxt.target_vel = 32'h00000000;
    endcase
    // Pulse follows the match both ways, pin gated by the enable
    st_nxt.pulse = match_now; // RL8 RL9
    st_nxt.diag = match_now && pulse_enable; // RL10
  end

  // Whole state in one register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.mode <= mmc_pkg::RAMP_RST;
      st_r.table_index <= mmc_pkg::LIDX_RST;
      st_r.compare <= mmc_pkg::CMP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign motion_profile_select = st_r.mode;
  assign ramp_full_profile = st_r.full_profile;
  assign ramp_target_velocity = st_r.target_vel;
  assign ramp_acceleration = st_r.accel;
  assign position_pulse = st_r.pulse;
  assign diagnostic_output_two = st_r.diag;
  assign table_words = mem_words;

  // Helpers for the checks; the word pick is only trusted below ten
  assign wr_commit = !st_r.awready && !st_r.wready && !st_r.bvalid;
  assign lut_pick = table_words[st_r.table_index[3:0]];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  chk_position_full: assert property ( // RL1
    st_r.mode == mmc_pkg::MODE_POSITION |=> ramp_full_profile)
    else $error("positioning mode lost full profile");
  chk_velocity_plus: assert property ( // RL2
    st_r.mode == mmc_pkg::MODE_VEL_POS |=>
      ramp_target_velocity == $past(velocity_limit) && !ramp_full_profile &&
      ramp_acceleration == $past(acceleration_limit))
    else $error("positive velocity target wrong");
  chk_velocity_minus: assert property ( // RL3
    st_r.mode == mmc_pkg::MODE_VEL_NEG |=>
      ramp_target_velocity == 32'h00000000 - $past(velocity_limit))
    else $error("negative velocity target wrong");
  chk_hold_keeps: assert property ( // RL4
    st_r.mode == mmc_pkg::MODE_HOLD && !stop_event |=>
      ramp_target_velocity == $past(present_velocity))
    else $error("hold mode changed velocity");
  chk_window_write: assert property ( // RL13
    mem_wr_en && st_r.w_strb == 4'hF |=>
      table_words[$past(st_r.table_index[3:0])] == $past(st_r.w_data))
    else $error("window write missed indexed word");
  chk_window_read: assert property ( // RL6
    st_r.arready && s_axi_arvalid && s_axi_araddr == {mmc_pkg::IDX_LWIN, 2'h0} &&
      st_r.table_index < mmc_pkg::LUT_WORDS && !mem_wr_en |=>
      ##1 s_axi_rvalid && s_axi_rdata == $past(lut_pick, 2))
    else $error("window read returned wrong word");
  chk_pulse_match: assert property ( // RL8
    repeat_distance <= mmc_pkg::REP_ONE && current_position == st_r.compare |=> position_pulse)
    else $error("pulse missing on match");
  chk_pulse_drop: assert property ( // RL9
    !match_now |=> !position_pulse)
    else $error("pulse stayed high on mismatch");
  chk_diag_gate: assert property ( // RL10
    !pulse_enable |=> !diagnostic_output_two)
    else $error("diagnostic pin driven while disabled");
  chk_repeat_step: assert property ( // RL12
    repeat_distance > mmc_pkg::REP_ONE &&
      current_position == st_r.compare - {8'h00, repeat_distance} |=> position_pulse)
    else $error("repeat pulse missing below base");
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  // Register paths and the remaining pulse and gate cases
  chk_accel_minus: assert property ( // RL3
    st_r.mode == mmc_pkg::MODE_VEL_NEG |=>
      ramp_acceleration == $past(acceleration_limit) && !ramp_full_profile)
    else $error("negative velocity acceleration wrong");
  chk_diag_follow: assert property ( // RL10
    pulse_enable && match_now |=> diagnostic_output_two)
    else $error("diagnostic pin missed enabled pulse");
  chk_repeat_base: assert property ( // RL11
    repeat_distance > mmc_pkg::REP_ONE && current_position == st_r.compare |=> position_pulse)
    else $error("repeat pulse missing at base");
  chk_index_write: assert property ( // RL5
    wr_commit && st_r.aw_addr == {mmc_pkg::IDX_LIDX, 2'h0} && st_r.w_strb[0] |=>
      st_r.table_index == $past(st_r.w_data[4:0]))
    else $error("index write not applied");
  chk_compare_write: assert property ( // RL7
    wr_commit && st_r.aw_addr == {mmc_pkg::IDX_CMP, 2'h0} && st_r.w_strb == 4'hF |=>
      st_r.compare == $past(st_r.w_data))
    else $error("compare write not applied");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_read_latency: assert property (
    s_axi_arready && s_axi_arvalid |=> ##1 s_axi_rvalid)
    else $error("read answer not two cycles after address");

  cov_window_write: cover property (mem_wr_en);
  cov_repeat_pulse: cover property (repeat_distance > mmc_pkg::REP_ONE && position_pulse);
  cov_hold_stop: cover property (st_r.mode == mmc_pkg::MODE_HOLD && stop_event);
  cov_diag_high: cover property (diagnostic_output_two);
  cov_window_read: cover property (st_r.rd_pend && ridx == mmc_pkg::IDX_LWIN);

endmodule : mmc_regs

/* File: mmc_pkg.sv */
package mmc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RAMP = 6'h07;
  localparam logic [5:0] IDX_LIDX = 6'h08;
  localparam logic [5:0] IDX_LWIN = 6'h09;
  localparam logic [5:0] IDX_CMP = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h20;
  localparam int ADDR_W = 8;

  // Field layouts
  localparam int MODE_W = 2;
  localparam int LIDX_W = 5;
  localparam int REP_W = 24;
  localparam int STAT_PULSE_BIT = 0;
  localparam int STAT_MODE_LSB = 2;

  // Motion profile encodings
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_VEL_POS = 2'h1;
  localparam logic [1:0] MODE_VEL_NEG = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;

  // Table slots behind the data window
  localparam logic [4:0] LUT_WORDS = 5'h0A;
  localparam logic [4:0] LUT_START_SLOT = 5'h08;
  localparam logic [4:0] LUT_SEL_SLOT = 5'h09;

  // Reset values
  localparam logic [1:0] RAMP_RST = 2'h0;
  localparam logic [4:0] LIDX_RST = 5'h00;
  localparam logic [31:0] WIN_RST = 32'hAAAAB554;
  localparam logic [31:0] LUT_OTHER_RST = 32'h00000000;
  localparam logic [31:0] CMP_RST = 32'hFFFFFFFF;
  localparam logic [23:0] REP_ONE = 24'h000001;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

endpackage : mmc_pkg

/* File: mmc_lut_mem.sv */
`timescale 1ns/1ps
module mmc_lut_mem (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic rd_en,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [mmc_pkg::LUT_WORDS-1:0][31:0] words
);

  typedef struct packed {
    logic [mmc_pkg::LUT_WORDS-1:0][31:0] words;
    logic [31:0] rd_data;
  } mmc_mem_t;

  mmc_mem_t st_r;
  mmc_mem_t st_nxt;

  // One word written per access, others untouched; read gives the old word
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.words[wr_idx] = mmc_pkg::merge(st_r.words[wr_idx], wr_data, wr_strb);
    end
    if (rd_en) begin
      st_nxt.rd_data = st_r.words[rd_idx];
    end
  end

  // Word zero wakes with the default sine segment
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{words: {{(mmc_pkg::LUT_WORDS-1){mmc_pkg::LUT_OTHER_RST}}, mmc_pkg::WIN_RST},
                rd_data: 32'h00000000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign words = st_r.words;

endmodule : mmc_lut_mem

/* File: mmc_host.sv */
`timescale 1ns/1ps
// Host-side bus master; payload held until taken, every wait bounded
module mmc_host (
  input wire logic ref_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r, output logic tmo);
    int n;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    r = bresp;
    tmo = (n == 40);
  endtask : wr

  // Read answer taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output logic tmo);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    tmo = (n == 40);
  endtask : rd
endmodule : mmc_host

/* File: mmc_regs_test.sv */
`timescale 1ns/1ps
module mmc_regs_test;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
                         logic [1:0] r;} mmc_row_t;
  typedef struct packed {logic [31:0] p; logic [23:0] rep; logic en; logic pul;
                         logic dia;} mmc_pos_t;
  localparam logic [31:0] VEL = 32'h00001000;
  localparam logic [31:0] PV = 32'h00000055;
  localparam logic [31:0] ACC = 32'h00000020;
  localparam logic [1:0] OK = mmc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = mmc_pkg::RESP_SLVERR;
  logic ref_clk = 1'b0, rst_b = 1'b0, stop_event = 1'b0, pulse_enable = 1'b0;
  logic [31:0] current_position = '0, present_velocity = PV, tv;
  logic [23:0] repeat_distance = '0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ramp_target_velocity, ramp_acceleration;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, motion_profile_select;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic ramp_full_profile, position_pulse, diagnostic_output_two;
  logic [mmc_pkg::LUT_WORDS-1:0][31:0] table_words;
  int bad_count = 0, comparisons = 0;
  mmc_row_t rows [10];
  mmc_pos_t pos [7];

  mmc_regs u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .current_position(current_position),
    .repeat_distance(repeat_distance), .pulse_enable(pulse_enable),
    .velocity_limit(VEL), .acceleration_limit(ACC),
    .present_velocity(present_velocity), .stop_event(stop_event),
    .motion_profile_select(motion_profile_select), .ramp_full_profile(ramp_full_profile),
    .ramp_target_velocity(ramp_target_velocity), .ramp_acceleration(ramp_acceleration),
    .position_pulse(position_pulse), .diagnostic_output_two(diagnostic_output_two),
    .table_words(table_words));

  mmc_host u_host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A bus hang counts as a mismatch and ends the run
  task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    logic t;
    u_host.wr(a, d, s, r, t);
    if (t) begin
      bad_count++;
      finish_test();
    end
    chk({30'h0, r}, {30'h0, er});
  endtask : bw

  task automatic br(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    logic t;
    u_host.rd(a, d, r, t);
    if (t) begin
      bad_count++;
      finish_test();
    end
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : br

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  initial begin
    rows = '{'{8'h1C, 32'h2, 4'hF, 32'h2, OK}, '{8'h40, 32'h12345678, 4'hF, 32'h12345678, OK},
      '{8'h40, 32'hAABBCCDD, 4'h1, 32'h123456DD, OK}, '{8'h20, 32'h5, 4'hF, 32'h5, OK},
      '{8'h24, 32'hCAFEF00D, 4'hF, 32'hCAFEF00D, OK}, '{8'h20, 32'h1F, 4'hF, 32'h1F, OK},
      '{8'h24, 32'h5A5A5A5A, 4'hF, 32'h0, OK}, '{8'h30, 32'h1, 4'hF, 32'h0, ERR},
      '{8'h22, 32'h1, 4'hF, 32'h0, ERR}, '{8'h80, 32'hFFFFFFFF, 4'hF, 32'h8, OK}};
    pos = '{'{32'h100, 24'h0, 1'b1, 1'b1, 1'b1}, '{32'h101, 24'h0, 1'b1, 1'b0, 1'b0},
      '{32'h100, 24'h0, 1'b0, 1'b1, 1'b0}, '{32'h130, 24'h10, 1'b1, 1'b1, 1'b1},
      '{32'hF0, 24'h10, 1'b1, 1'b1, 1'b1}, '{32'h138, 24'h10, 1'b1, 1'b0, 1'b0},
      '{32'h200, 24'h1, 1'b1, 1'b0, 1'b0}};
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Write then read back each row
    foreach (rows[i]) begin
      bw(rows[i].a, rows[i].d, rows[i].s, rows[i].r);
      br(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("register rows done");
    // Every motion profile code, then a stop event in hold
    for (int m = 0; m < 4; m++) begin
      bw(8'h1C, 32'(m), 4'hF, OK);
      tv = (m == 2) ? -VEL : (m == 3) ? PV : VEL;
      tick(2);
      chk(ramp_target_velocity, tv);
      chk({31'h0, ramp_full_profile}, {31'h0, m == 0});
      chk({30'h0, motion_profile_select}, 32'(m));
      chk(ramp_acceleration, ACC);
    end
    @(posedge ref_clk);
    stop_event <= 1'b1;
    tick(2);
    chk(ramp_target_velocity, 32'h0);
    $display("profile test done");
    // Absolute compare, repeat distance both ways, enable gating
    bw(8'h40, 32'h00000100, 4'hF, OK);
    foreach (pos[i]) begin
      @(posedge ref_clk);
      current_position <= pos[i].p;
      repeat_distance <= pos[i].rep;
      pulse_enable <= pos[i].en;
      tick(2);
      chk({31'h0, position_pulse}, {31'h0, pos[i].pul});
      chk({31'h0, diagnostic_output_two}, {31'h0, pos[i].dia});
    end
    $display("compare test done");
    // Reset in mid-run restores mode, table index, window word zero and compare
    @(posedge ref_clk);
    rst_b <= 1'b0;
    tick(2);
    chk({30'h0, motion_profile_select}, 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    br(8'h1C, 32'h0, OK);
    br(8'h20, 32'h0, OK);
    br(8'h24, mmc_pkg::WIN_RST, OK);
    br(8'h40, mmc_pkg::CMP_RST, OK);
    $display("reset test done");
    // Start and segment slots behind the window
    bw(8'h20, 32'h8, 4'hF, OK);
    bw(8'h24, 32'h11111111, 4'hF, OK);
    bw(8'h20, 32'h9, 4'hF, OK);
    bw(8'h24, 32'h22222222, 4'hF, OK);
    br(8'h24, 32'h22222222, OK);
    tick(1);
    chk(table_words[8], 32'h11111111);
    chk(table_words[9], 32'h22222222);
    chk(table_words[0], mmc_pkg::WIN_RST);
    $display("table slot test done");
    finish_test();
  end
endmodule : mmc_regs_test
